// File: rtl/dsc_top.sv
// serial slave front end: frame check and drive command register map
// How it works
// - ascii check is two's complement of byte sum modulo 256
// - rtu crc starts at all ones for each frame
// - each byte is xored into the crc low byte first
// - each step shifts right, zero in, xor a001 if a one left
// - exactly eight steps per byte before the next fold
// - fold and steps repeat over every byte; final value is the crc
// - crc travels low byte first, high byte second
// - parameter address is group in high byte, index in low byte
// - command bits 3:0 give none, stop, run, jog plus run
// - command bits 5:4 give none, forward, reverse, toggle direction
// - command bits 7:6 pick one of four ramp sets
// - command bits 11:8 pick one of sixteen step speeds
// - command bit 12 set makes ramp and step fields ignored
// - command bits 14:13 give none, keypad, setting source, toggle source
// - control bit 0 outside fault, bit 1 fault reset, bit 2 base block
// - a frame with a check error gets no reply at all
// - unhandled valid frame gets function with top bit set, plus cause
`timescale 1ns/1ps
`include "dsc_params.svh"

module dsc_top (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic ascii_mode_in,
   input wire logic [7:0] station_addr_in,
   input wire logic rx_start_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic rx_end_in,
   output logic rx_ready_out,
   output logic check_error_out,
   output logic resp_valid_out,
   output logic [7:0] resp_func_out,
   output logic [7:0] resp_exc_out,
   output logic [15:0] resp_data_out,
   output logic param_valid_out,
   output logic param_write_out,
   output logic [7:0] param_group_out,
   output logic [7:0] param_index_out,
   output logic [15:0] param_data_out,
   output logic run_out,
   output logic jog_out,
   output dsc_pkg::dsc_dir_e direction_out,
   output logic [1:0] ramp_set_out,
   output logic [3:0] step_speed_out,
   output dsc_pkg::dsc_src_e op_source_out,
   output logic [15:0] freq_target_out,
   output logic outside_fault_flag_out,
   output logic fault_reset_out,
   output logic base_block_out
);
   import dsc_pkg::*;

   dsc_state_e state;
   dsc_state_e next_state;
   logic [7:0] nbytes;
   logic [7:0] hold1;
   logic [7:0] hold2;
   logic [7:0] frame_mem [0:5];
   logic [7:0] err_count;
   logic [7:0] last_exc;

   // byte intake: the last one or two bytes are held back as check bytes
   wire [7:0] need = ascii_mode_in ? `DSC_LRC_BYTES : `DSC_CRC_BYTES;
   wire take = ce_in && state == DSC_COLLECT && rx_valid_in && rx_ready_out;
   wire feed = take && (nbytes >= need);
   wire [7:0] feed_byte = ascii_mode_in ? hold1 : hold2;
   wire start_ok = ce_in && state == DSC_IDLE && rx_start_in;
   wire unit_busy;
   wire [15:0] calc_crc;
   wire [7:0] calc_lrc;

   dsc_check_unit u_check (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .ce_in(ce_in),
      .start_in(start_ok),
      .byte_valid_in(feed),
      .byte_in(feed_byte),
      .busy_out(unit_busy),
      .crc_out(calc_crc),
      .lrc_out(calc_lrc)
   );

   // check compare; older held byte is the crc low byte
   wire [15:0] rx_check = ascii_mode_in ? {8'h00, hold1} : {hold1, hold2};
   wire [15:0] calc_check = ascii_mode_in ? {8'h00, calc_lrc} : calc_crc;
   wire too_short = nbytes < (need + `DSC_MIN_PAYLOAD);
   wire check_ok = !too_short && (rx_check == calc_check);
   wire do_eval = ce_in && state == DSC_CHECK && !unit_busy;

   // frame field decode
   wire [7:0] fn = frame_mem[1];
   wire [15:0] reg_addr = {frame_mem[2], frame_mem[3]};
   wire [15:0] word = {frame_mem[4], frame_mem[5]};
   wire [7:0] payload_len = nbytes - need;
   wire for_us = frame_mem[0] == station_addr_in;
   wire accept = check_ok && for_us;
   wire is_wr = fn == `DSC_FN_WRITE;
   wire is_rd = fn == `DSC_FN_READ;
   wire len_ok = payload_len == `DSC_WRITE_LEN;
   wire param_sp = reg_addr[15:8] < `DSC_PARAM_TOP;
   wire known_wr = reg_addr == `DSC_REG_CMD || reg_addr == `DSC_REG_FREQ
      || reg_addr == `DSC_REG_CTRL;
   wire known = is_wr ? known_wr : reg_addr == `DSC_REG_MON;
   wire bad_count = is_rd && (param_sp || reg_addr == `DSC_REG_MON)
      && word != `DSC_PARAM_READ_MAX;

   // exception cause, most basic fault first
   wire [7:0] exc_code = (!is_wr && !is_rd) ? `DSC_EXC_FUNC
      : !len_ok ? `DSC_EXC_VALUE
      : bad_count ? `DSC_EXC_VALUE
      : (param_sp || known) ? `DSC_EXC_NONE
      : `DSC_EXC_ADDR;
   wire ok_frame = do_eval && accept && exc_code == `DSC_EXC_NONE;
   // parameter space is answered by the parameter store, not here
   wire reply_now = do_eval && accept && !(exc_code == `DSC_EXC_NONE && param_sp);
   wire cmd_wr = ok_frame && is_wr && reg_addr == `DSC_REG_CMD;
   wire freq_wr = ok_frame && is_wr && reg_addr == `DSC_REG_FREQ;
   wire ctrl_wr = ok_frame && is_wr && reg_addr == `DSC_REG_CTRL;
   wire [15:0] monitor = {err_count, last_exc};

   // command word fields
   wire [3:0] run_code = word[`DSC_RUN_LSB +: 4];
   wire [1:0] dir_code = word[`DSC_DIR_LSB +: 2];
   wire [1:0] src_code = word[`DSC_SRC_LSB +: 2];
   wire hold_sel = word[`DSC_HOLD_BIT];

   // run action: 1 stop, 2 run, 3 jog plus run, others keep
   wire next_run = (run_code == 4'h1) ? 1'b0
      : (run_code == 4'h2 || run_code == 4'h3) ? 1'b1 : run_out;
   wire next_jog = (run_code == 4'h1 || run_code == 4'h2) ? 1'b0
      : (run_code == 4'h3) ? 1'b1 : jog_out;
   // direction: 01 forward, 10 reverse, 11 toggle
   wire dsc_dir_e next_dir = (dir_code == 2'h1) ? DSC_FORWARD_ROTATION
      : (dir_code == 2'h2) ? DSC_REVERSE_ROTATION
      : (dir_code == 2'h3) ? dsc_dir_e'(~direction_out) : direction_out;
   // source: 01 keypad, 10 setting, 11 toggle
   wire dsc_src_e next_src = (src_code == 2'h1) ? DSC_SRC_KEYPAD
      : (src_code == 2'h2) ? DSC_SRC_OPERATION_SOURCE_SETTING
      : (src_code == 2'h3) ? dsc_src_e'(~op_source_out) : op_source_out;
   wire next_fault = word[`DSC_EF_BIT] ? 1'b1
      : word[`DSC_RST_BIT] ? 1'b0 : outside_fault_flag_out;

   // frame sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         DSC_IDLE: begin
            if (rx_start_in) begin
               next_state = DSC_COLLECT;
            end
         end
         DSC_COLLECT: begin
            if (rx_end_in) begin
               next_state = DSC_CHECK;
            end
         end
         DSC_CHECK: begin
            if (!unit_busy) begin
               next_state = DSC_IDLE;
            end
         end
         default: begin
            next_state = DSC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state <= DSC_IDLE;
      end else if (ce_in) begin
         state <= next_state;
      end
   end

   // byte count and held check bytes
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         nbytes <= 8'h00;
         hold1 <= 8'h00;
         hold2 <= 8'h00;
      end else if (start_ok) begin
         nbytes <= 8'h00;
      end else if (take) begin
         nbytes <= (nbytes == 8'hff) ? nbytes : nbytes + 8'h01;
         hold1 <= rx_byte_in;
         hold2 <= hold1;
      end
   end

   // storage by index; bytes past the sixth only feed the check
   always_ff @(posedge sys_clk_in) begin
      if (take && nbytes < `DSC_MEM_DEPTH) begin
         frame_mem[nbytes[2:0]] <= rx_byte_in;
      end
   end

   // intake ready only while collecting and the engine is free
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         rx_ready_out <= 1'b0;
      end else if (ce_in) begin
         rx_ready_out <= next_state == DSC_COLLECT && !feed && !unit_busy;
      end
   end

   // answer: check error is silent, else echo or exception
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         check_error_out <= 1'b0;
         resp_valid_out <= 1'b0;
         resp_func_out <= 8'h00;
         resp_exc_out <= 8'h00;
         resp_data_out <= 16'h0000;
      end else if (ce_in) begin
         check_error_out <= do_eval && !check_ok;
         resp_valid_out <= reply_now;
         if (reply_now) begin
            resp_exc_out <= exc_code;
            resp_func_out <= (exc_code != `DSC_EXC_NONE) ? (fn | `DSC_EXC_FLAG) : fn;
            resp_data_out <= is_rd ? monitor : word;
         end
      end
   end

   // error code monitor: check errors seen and last cause
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         err_count <= 8'h00;
         last_exc <= `DSC_EXC_NONE;
      end else if (ce_in) begin
         if (do_eval && !check_ok && err_count != 8'hff) begin
            err_count <= err_count + 8'h01; // saturates, never wraps to look clean
         end
         if (reply_now && exc_code != `DSC_EXC_NONE) begin
            last_exc <= exc_code;
         end
      end
   end

   // parameter space access handed to the parameter store
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         param_valid_out <= 1'b0;
         param_write_out <= 1'b0;
         param_group_out <= 8'h00;
         param_index_out <= 8'h00;
         param_data_out <= 16'h0000;
      end else if (ce_in) begin
         param_valid_out <= ok_frame && param_sp;
         if (ok_frame && param_sp) begin
            param_write_out <= is_wr;
            param_group_out <= reg_addr[15:8];
            param_index_out <= reg_addr[7:0];
            param_data_out <= word;
         end
      end
   end

   // command register effects
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         run_out <= 1'b0;
         jog_out <= 1'b0;
         direction_out <= DSC_FORWARD_ROTATION;
         ramp_set_out <= `DSC_RAMP_RST;
         step_speed_out <= `DSC_STEP_RST;
         op_source_out <= DSC_SRC_KEYPAD;
      end else if (ce_in && cmd_wr) begin
         run_out <= next_run;
         jog_out <= next_jog;
         direction_out <= next_dir;
         op_source_out <= next_src;
         if (!hold_sel) begin
            ramp_set_out <= word[`DSC_RAMP_LSB +: 2];
            step_speed_out <= word[`DSC_STEP_LSB +: 4];
         end
      end
   end

   // frequency and control words; an outside fault set beats a reset
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         freq_target_out <= `DSC_FREQ_RST;
         outside_fault_flag_out <= 1'b0;
         fault_reset_out <= 1'b0;
         base_block_out <= 1'b0;
      end else if (ce_in) begin
         fault_reset_out <= ctrl_wr && word[`DSC_RST_BIT];
         if (freq_wr) begin
            freq_target_out <= word;
         end
         if (ctrl_wr) begin
            outside_fault_flag_out <= next_fault;
            base_block_out <= word[`DSC_BB_BIT];
         end
      end
   end

   a_no_reply_err: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (do_eval && !check_ok) |=> check_error_out && !resp_valid_out)
      else $error("reply sent for a frame with a check error");
   a_exc_top_bit: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (resp_valid_out && resp_exc_out != 8'h00) |-> resp_func_out[7])
      else $error("exception reply without top function bit");
   a_accept_match: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (resp_valid_out || param_valid_out) |-> $past(check_ok))
      else $error("frame acted on without matching check");
   a_hold_ramp: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (cmd_wr && hold_sel) |=> ramp_set_out == $past(ramp_set_out)
         && step_speed_out == $past(step_speed_out))
      else $error("ramp or step changed despite hold bit");
   a_freq_load: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      freq_wr |=> freq_target_out == $past(word) ##1 (freq_target_out == $past(word, 2)
         || $past(freq_wr)))
      else $error("frequency word not loaded");

   // engine needs its eight steps, so intake stays shut meanwhile
   sequence s_byte_fed;
      take && feed;
   endsequence

   a_fed_ready_low: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_byte_fed |=> (!rx_ready_out) [*8])
      else $error("intake reopened before the bit steps ended");
   a_ctrl_bits: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      ctrl_wr |=> base_block_out == $past(word[`DSC_BB_BIT])
         && fault_reset_out == $past(word[`DSC_RST_BIT]))
      else $error("control word bits not applied");
   a_exc_echo: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (reply_now && exc_code != `DSC_EXC_NONE) |=> resp_exc_out == $past(exc_code))
      else $error("exception cause not returned");
   a_param_map: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (ok_frame && param_sp) |=> param_valid_out && param_group_out == $past(reg_addr[15:8])
         && param_index_out == $past(reg_addr[7:0]))
      else $error("parameter address not split into group and index");
   a_run_jog: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (cmd_wr && run_code == 4'h3) |=> run_out && jog_out)
      else $error("jog plus run not applied");
endmodule

// File: rtl/dsc_params.svh
// offsets, field positions, reset values and counts of the serial check and command map
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// register addresses carried in the frames
`define DSC_REG_CMD 16'h2000
`define DSC_REG_FREQ 16'h2001
`define DSC_REG_CTRL 16'h2002
`define DSC_REG_MON 16'h2100
// group numbers below this are the parameter space
`define DSC_PARAM_TOP 8'h20
`define DSC_PARAM_READ_MAX 16'h0001

// function and exception codes
`define DSC_FN_READ 8'h03
`define DSC_FN_WRITE 8'h06
`define DSC_EXC_FLAG 8'h80
`define DSC_EXC_NONE 8'h00
`define DSC_EXC_FUNC 8'h01
`define DSC_EXC_ADDR 8'h02
`define DSC_EXC_VALUE 8'h03

// check arithmetic
`define DSC_CRC_PRESET 16'hffff
`define DSC_CRC_POLY 16'ha001
`define DSC_BIT_STEPS 4'h8
`define DSC_LRC_BYTES 8'h01
`define DSC_CRC_BYTES 8'h02
`define DSC_MIN_PAYLOAD 8'h02
`define DSC_WRITE_LEN 8'h06
`define DSC_MEM_DEPTH 8'h06

// command word fields
`define DSC_RUN_LSB 0
`define DSC_DIR_LSB 4
`define DSC_RAMP_LSB 6
`define DSC_STEP_LSB 8
`define DSC_HOLD_BIT 12
`define DSC_SRC_LSB 13
// control word fields
`define DSC_EF_BIT 0
`define DSC_RST_BIT 1
`define DSC_BB_BIT 2

// reset values
`define DSC_FREQ_RST 16'h0000
`define DSC_RAMP_RST 2'h0
`define DSC_STEP_RST 4'h0

`endif

// File: rtl/dsc_pkg.sv
// types shared by the serial check and command map
package dsc_pkg;
   typedef enum logic [1:0] {
      DSC_IDLE = 2'b00,
      DSC_COLLECT = 2'b01,
      DSC_CHECK = 2'b11
   } dsc_state_e;

   typedef enum logic {
      DSC_FORWARD_ROTATION = 1'b0,
      DSC_REVERSE_ROTATION = 1'b1
   } dsc_dir_e;

   typedef enum logic {
      DSC_SRC_KEYPAD = 1'b0,
      DSC_SRC_OPERATION_SOURCE_SETTING = 1'b1
   } dsc_src_e;
endpackage

// File: rtl/dsc_check_unit.sv
// bit-serial crc and longitudinal sum engine, one byte at a time
`timescale 1ns/1ps
`include "dsc_params.svh"

module dsc_check_unit (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic start_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   output logic busy_out,
   output logic [15:0] crc_out,
   output logic [7:0] lrc_out
);
   import dsc_pkg::*;

   logic [3:0] steps;
   logic [7:0] sum;
   logic [15:0] next_step;
   logic [7:0] next_sum;

   // one shift right with zero fill, then the polynomial if a one fell out
   function automatic logic [15:0] dsc_crc_shift(input logic [15:0] v);
      dsc_crc_shift = {1'b0, v[15:1]} ^ (v[0] ? `DSC_CRC_POLY : 16'h0000);
   endfunction

   assign next_step = dsc_crc_shift(crc_out);
   assign next_sum = sum + byte_in; // modulo 256 by width
   assign lrc_out = 8'h00 - sum; // two's complement of the sum

   // byte fold, then eight steps; new bytes wait while busy
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         crc_out <= `DSC_CRC_PRESET;
         sum <= 8'h00;
         steps <= 4'h0;
         busy_out <= 1'b0;
      end else if (ce_in) begin
         if (start_in) begin
            crc_out <= `DSC_CRC_PRESET;
            sum <= 8'h00;
            steps <= 4'h0;
            busy_out <= 1'b0;
         end else if (byte_valid_in && !busy_out) begin
            crc_out <= crc_out ^ {8'h00, byte_in};
            sum <= next_sum;
            steps <= `DSC_BIT_STEPS;
            busy_out <= 1'b1;
         end else if (busy_out) begin
            crc_out <= next_step;
            steps <= steps - 4'h1;
            busy_out <= (steps != 4'h1);
         end
      end
   end

   sequence s_byte_taken;
      ce_in && !start_in && byte_valid_in && !busy_out;
   endsequence

   a_crc_preset: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (ce_in && start_in) |=> crc_out == 16'hffff)
      else $error("crc not preset at frame start");
   a_byte_fold: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_byte_taken |=> (crc_out == ($past(crc_out) ^ {8'h00, $past(byte_in)})) && busy_out)
      else $error("byte not folded into low crc byte");
   a_bit_step: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (ce_in && !start_in && busy_out) |=> crc_out == dsc_crc_shift($past(crc_out)))
      else $error("crc bit step wrong");
   a_eight_steps: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (s_byte_taken ##1 ce_in [*8]) |=> !busy_out)
      else $error("byte did not take exactly eight steps");
   a_steps_busy: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (s_byte_taken ##1 ce_in [*7]) |-> busy_out)
      else $error("steps ended early");
   a_lrc_sum: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      s_byte_taken |=> lrc_out == 8'h00 - ($past(sum) + $past(byte_in)))
      else $error("longitudinal check wrong");
endmodule

// File: tb/dsc_master_model.sv
// serial master model: frames six payload bytes and appends their check
`timescale 1ns/1ps
module dsc_master_model (
   input wire logic sys_clk_in,
   input wire logic ascii_mode_in,
   input wire logic rx_ready_in,
   output logic rx_start_out,
   output logic rx_valid_out,
   output logic [7:0] rx_byte_out,
   output logic rx_end_out
);
   // idle lines at time zero
   initial begin
      rx_start_out = 1'b0;
      rx_valid_out = 1'b0;
      rx_byte_out = 8'h00;
      rx_end_out = 1'b0;
   end

   // ascii check: negated byte sum modulo 256
   function automatic logic [7:0] sum_check(input logic [47:0] f);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 6; i++) s = s + f[47-8*i -: 8];
      return ~s + 8'h01;
   endfunction

   // rtu check, bit by bit as the device folds it
   function automatic logic [15:0] crc_check(input logic [47:0] f);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 0; i < 6; i++) begin
         c[7:0] = c[7:0] ^ f[47-8*i -: 8];
         for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction

   // wait for ready, present one byte for one taken edge
   task automatic put_byte(input logic [7:0] b, inout bit hung);
      int n;
      n = 0;
      while (rx_ready_in !== 1'b1 && n < 60) begin
         @(negedge sys_clk_in);
         n++;
      end
      if (n == 60) hung = 1'b1;
      rx_byte_out = b;
      rx_valid_out = 1'b1;
      @(negedge sys_clk_in);
      rx_valid_out = 1'b0;
      rx_byte_out = ~b; // released line shows no stale value
      @(negedge sys_clk_in);
   endtask

   // one whole frame; bad flips a check bit on purpose
   task automatic send(input logic [47:0] f, input bit bad, output bit hung);
      logic [15:0] c;
      hung = 1'b0;
      c = crc_check(f);
      rx_start_out = 1'b1;
      @(negedge sys_clk_in);
      rx_start_out = 1'b0;
      for (int i = 0; i < 6; i++) put_byte(f[47-8*i -: 8], hung);
      if (ascii_mode_in) begin
         put_byte(sum_check(f) ^ {7'h00, bad}, hung);
      end else begin
         put_byte(c[7:0] ^ {7'h00, bad}, hung);
         put_byte(c[15:8], hung);
      end
      // frame end strobe for one taken edge; the engine may still be stepping
      rx_end_out = 1'b1;
      @(negedge sys_clk_in);
      rx_end_out = 1'b0;
   endtask
endmodule

// File: tb/dsc_top_tb.sv
// self-checking bench for the serial check and command map
`timescale 1ns/1ps
module dsc_top_tb;
   import dsc_pkg::*;
   logic sys_clk_in, reset_in, ascii_mode_in, rx_start_in, rx_valid_in, rx_end_in;
   logic [7:0] rx_byte_in, resp_func_out, resp_exc_out, param_group_out, param_index_out;
   logic rx_ready_out, check_error_out, resp_valid_out, param_valid_out, param_write_out;
   logic [15:0] resp_data_out, param_data_out, freq_target_out;
   logic run_out, jog_out, outside_fault_flag_out, fault_reset_out, base_block_out;
   logic [1:0] ramp_set_out;
   logic [3:0] step_speed_out;
   dsc_dir_e direction_out;
   dsc_src_e op_source_out;
   int err_count, n_tests;
   bit got_resp, got_err, got_par, saw_fr;

   dsc_top dsc_top_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .ce_in(1'b1),
      .ascii_mode_in(ascii_mode_in), .station_addr_in(8'h01), .rx_start_in(rx_start_in),
      .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in), .rx_end_in(rx_end_in),
      .rx_ready_out(rx_ready_out), .check_error_out(check_error_out),
      .resp_valid_out(resp_valid_out), .resp_func_out(resp_func_out),
      .resp_exc_out(resp_exc_out), .resp_data_out(resp_data_out),
      .param_valid_out(param_valid_out), .param_write_out(param_write_out),
      .param_group_out(param_group_out), .param_index_out(param_index_out),
      .param_data_out(param_data_out), .run_out(run_out), .jog_out(jog_out),
      .direction_out(direction_out), .ramp_set_out(ramp_set_out),
      .step_speed_out(step_speed_out), .op_source_out(op_source_out),
      .freq_target_out(freq_target_out), .outside_fault_flag_out(outside_fault_flag_out),
      .fault_reset_out(fault_reset_out), .base_block_out(base_block_out));

   dsc_master_model dsc_master_model_inst (.sys_clk_in(sys_clk_in),
      .ascii_mode_in(ascii_mode_in), .rx_ready_in(rx_ready_out),
      .rx_start_out(rx_start_in), .rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in),
      .rx_end_out(rx_end_in));

   // 100 ns period
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // send a frame and wait, bounded, for whatever the block answers
   task automatic run_frame(input logic [47:0] f, input bit bad);
      bit hung;
      int n;
      {got_resp, got_err, got_par, saw_fr} = 4'h0;
      dsc_master_model_inst.send(f, bad, hung);
      n = 0;
      while (!(got_resp | got_err | got_par) && n < 80) begin
         @(negedge sys_clk_in);
         n++;
         got_resp = (resp_valid_out === 1'b1);
         got_err = (check_error_out === 1'b1);
         got_par = (param_valid_out === 1'b1);
         saw_fr = saw_fr | (fault_reset_out === 1'b1);
      end
      @(negedge sys_clk_in);
      saw_fr = saw_fr | (fault_reset_out === 1'b1);
      if (hung || n == 80) begin
         err_count++;
         $display("[FAIL] frame answer expected 1 seen 0");
         tally_and_finish;
      end
   endtask

   // plain write with a normal echo reply
   task automatic write_ok(input logic [15:0] a, input logic [15:0] d);
      run_frame({8'h01, 8'h06, a, d}, 1'b0);
      check("reply", {got_resp, resp_func_out, resp_exc_out, resp_data_out},
         {1'b1, 8'h06, 8'h00, d});
   endtask

   task automatic t_reset;
      check("reset outputs", {run_out, jog_out, direction_out, ramp_set_out, step_speed_out,
         op_source_out, freq_target_out, outside_fault_flag_out, base_block_out}, 32'h0);
   endtask

   task automatic t_freq;
      write_ok(16'h2001, 16'h1770);
      check("freq rtu", freq_target_out, 16'h1770);
      ascii_mode_in = 1'b1;
      write_ok(16'h2001, 16'h0bb8);
      check("freq ascii", freq_target_out, 16'h0bb8);
      ascii_mode_in = 1'b0;
   endtask

   // corrupted check: error pulse only, no reply, nothing written
   task automatic t_bad;
      run_frame({8'h01, 8'h06, 16'h2001, 16'h1234}, 1'b1);
      check("bad check", {got_err, got_resp, freq_target_out}, {2'b10, 16'h0bb8});
   endtask

   // command word table: {run, jog, dir, ramp, step, src}
   task automatic t_cmd;
      logic [15:0] d[5];
      logic [9:0] e[5];
      d = '{16'h2592, 16'h5fe3, 16'h6971, 16'h0002, 16'h003f};
      e = '{10'h24a, 10'h3cb, 10'h032, 10'h200, 10'h280};
      for (int i = 0; i < 5; i++) begin
         write_ok(16'h2000, d[i]);
         check("command fields", {run_out, jog_out, direction_out, ramp_set_out,
            step_speed_out, op_source_out}, e[i]);
      end
   endtask

   // control word: {fault, base block, fault reset pulse}
   task automatic t_ctrl;
      logic [15:0] d[3];
      logic [2:0] e[3];
      d = '{16'hfff9, 16'h0006, 16'h0003};
      e = '{3'h4, 3'h3, 3'h5};
      for (int i = 0; i < 3; i++) begin
         write_ok(16'h2002, d[i]);
         check("control bits", {outside_fault_flag_out, base_block_out, saw_fr}, e[i]);
      end
   endtask

   // unknown function, then unknown register
   task automatic t_exc;
      run_frame({8'h01, 8'h05, 16'h2001, 16'h0000}, 1'b0);
      check("bad function", {got_resp, resp_func_out, resp_exc_out}, {1'b1, 16'h8501});
      run_frame({8'h01, 8'h06, 16'h2050, 16'h0000}, 1'b0);
      check("bad address", {got_resp, resp_func_out, resp_exc_out}, {1'b1, 16'h8602});
   endtask

   task automatic t_param;
      run_frame({8'h01, 8'h06, 16'h0401, 16'h1388}, 1'b0);
      check("param write", {got_par, param_write_out, param_group_out, param_index_out,
         param_data_out}, {2'b11, 16'h0401, 16'h1388});
      run_frame({8'h01, 8'h03, 16'h2100, 16'h0001}, 1'b0);
      check("monitor read", {got_resp, resp_func_out, resp_exc_out}, {1'b1, 16'h0300});
      check("monitor data", resp_data_out, 16'h0102);
   endtask

   initial begin
      reset_in = 1'b1;
      ascii_mode_in = 1'b0;
      err_count = 0;
      n_tests = 0;
      repeat (8) @(negedge sys_clk_in);
      t_reset;
      reset_in = 1'b0;
      @(negedge sys_clk_in);
      t_freq;
      t_bad;
      t_cmd;
      t_ctrl;
      t_exc;
      t_param;
      // second reset in mid-run must clear every command effect
      reset_in = 1'b1;
      @(negedge sys_clk_in);
      t_reset;
      reset_in = 1'b0;
      @(negedge sys_clk_in);
      tally_and_finish;
   end
endmodule
